// [dsm_consts.svh]
// Bit positions, widths and reset values for the dual synthesizer mode control
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH

// Serial word: 22 bits, data in [21:2], word select in [1:0]
`define DSM_SR_W         22
`define DSM_DATA_MSB     21
`define DSM_DATA_LSB     2
`define DSM_WORD_W       20
`define DSM_WSEL_HI      1
`define DSM_WSEL_LO      0

// Word select codes
`define DSM_WSEL_AUX_REF 2'h0
`define DSM_WSEL_MAIN_REF 2'h1
`define DSM_WSEL_AUX_DIV 2'h2
`define DSM_WSEL_MAIN_DIV 2'h3

// Loop indices
`define DSM_AUX          0
`define DSM_MAIN         1

// Reference word fields, positions inside the 20-bit latched word
`define DSM_R_CNT_W      15
`define DSM_R_CNT_LSB    0
`define DSM_R_CNT_MSB    14
`define DSM_POL_BIT      15
`define DSM_CUR_BIT      16
`define DSM_FLT_BIT      17
`define DSM_LOCK_BIT     18
`define DSM_FUNC_BIT     19

// Divider word fields: swallow, main counter, prescaler select (0 = 64/65, 1 = 128/129), powerdown
`define DSM_A_CNT_W      7
`define DSM_A_CNT_LSB    0
`define DSM_A_CNT_MSB    6
`define DSM_B_CNT_W      11
`define DSM_B_CNT_LSB    7
`define DSM_B_CNT_MSB    17
`define DSM_PSC_BIT      18
`define DSM_PWD_BIT      19

// Reset values
`define DSM_WORD_RST     20'h00000
`define DSM_SR_RST       22'h000000

`endif

// [dsm_pkg.sv]
// Types shared by the dual synthesizer mode control
package dsm_pkg;

  // Status pin function decoded from the lock-detect and function-output bits
  typedef enum logic [3:0] {
    dsm_st_off, dsm_st_lock_aux, dsm_st_lock_main, dsm_st_lock_both,
    dsm_st_ref_aux, dsm_st_ref_main, dsm_st_fb_aux, dsm_st_fb_main,
    dsm_st_damp_sw, dsm_st_rst_aux, dsm_st_rst_main, dsm_st_rst_both
  } dsm_status_t;

  // Per-loop power state
  typedef enum logic [1:0] {
    dsm_pwr_up, dsm_pwr_wait, dsm_pwr_down
  } dsm_pwr_t;

endpackage : dsm_pkg

// [dsm_prog_div.sv]
// Programmable binary divider: one terminal pulse every ratio ticks
`timescale 1ns/1ps
module dsm_prog_div #(
  parameter int W = 15
) (
  input  wire logic         ref_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         hold_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio_in,
  output logic              tc_out
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tc;

  // Count down from the ratio; hold parks the counter in its load state
  always_comb begin
    next_count = count;
    next_tc    = 1'b0;
    if (hold_in) begin
      next_count = ratio_in;
    end else if (tick_in) begin
      if (count <= W'(1)) begin
        next_count = ratio_in; // New ratio is picked up at the cycle boundary
        next_tc    = 1'b1;
      end else begin
        next_count = count - W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count  <= '0;
      tc_out <= 1'b0;
    end else begin
      count  <= next_count;
      tc_out <= next_tc;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_tc_from_tick: assert property (tc_out |-> $past(tick_in) && !$past(hold_in))
    else $error("divider pulse without a tick or while held");
  a_hold_quiet: assert property (hold_in [*2] |-> !tc_out)
    else $error("divider pulsed while held");

endmodule : dsm_prog_div

// [dsm_mode_ctrl.sv]
// Dual synthesizer mode control: serial load, dividers, powerdown and status pin
//
// Behaviour
// - Feedback divides by prescaler modulus times main count plus swallow count.
// - Reference counter is a 15-bit divider for ratios 3 to 32767.
// - Prescaler bit low selects 64/65, high selects 128/129.
// - Reference word mode bits go to aux loop for 00, main loop for 01.
// - Polarity bit low gives negative, high gives positive phase detector sense.
// - Powerdown bit low keeps the loop up, high powers it down.
// - All select bits zero disables the status pin, driven low.
// - Function bits low: status pin shows lock of selected loop or loops.
// - Lock mode: pin high while locked, with narrow low pulses.
// - Combined lock mode shows lock only when both loops are locked.
// - Aux lock bit low, one function bit high: show that reference divider.
// - Aux lock bit high, one function bit high: show that feedback divider.
// - Lock bits low, function bits high: open-drain ground while pump current high.
// - Only aux lock bit set in reset mode: aux counters reset, pump floats.
// - Only main lock bit set in reset mode: main counters reset, pump floats.
// - All four bits high: every counter reset, both pumps float.
// - Shift 22 bits MSB first on rising clock; latch on rising load strobe.
// - Word select 00/01/10/11 routes to aux ref, main ref, aux div, main div.
// - Float bit floats the pump; with powerdown it forces immediate powerdown.
// - Powerdown is immediate if float set at load, else waits for idle pump.
`timescale 1ns/1ps
`include "dsm_consts.svh"
module dsm_mode_ctrl (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ser_clk_in,
  input  wire logic       ser_data_in,
  input  wire logic       load_strobe_in,
  input  wire logic [1:0] presc_pulse_in,
  output logic      [1:0] mod_ctl_out,
  output logic      [1:0] prescaler_sel_out,
  output logic      [1:0] pump_src_out,
  output logic      [1:0] pump_snk_out,
  output logic      [1:0] pump_float_out,
  output logic      [1:0] pump_current_sel_out,
  output logic      [1:0] powerdown_out,
  output logic            osc_enable_out,
  output logic            status_mux_pin_out,
  output logic            status_mux_pin_oe_out
);

  // Pin synchronisers: first stage read only by the second
  logic [2:0] ser_clk_sync;
  logic [1:0] ser_data_sync;
  logic [2:0] load_sync;
  logic [1:0] presc_meta;
  logic [1:0] presc_sync;
  logic [1:0] presc_last;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ser_clk_sync  <= 3'h0;
      ser_data_sync <= 2'h0;
      load_sync     <= 3'h0;
      presc_meta    <= 2'h0;
      presc_sync    <= 2'h0;
      presc_last    <= 2'h0;
    end else begin
      ser_clk_sync  <= {ser_clk_sync[1:0], ser_clk_in};
      ser_data_sync <= {ser_data_sync[0], ser_data_in};
      load_sync     <= {load_sync[1:0], load_strobe_in};
      presc_meta    <= presc_pulse_in;
      presc_sync    <= presc_meta;
      presc_last    <= presc_sync;
    end
  end

  logic       clk_rise;
  logic       load_rise;
  logic [1:0] presc_edge;
  assign clk_rise   = ser_clk_sync[1] & ~ser_clk_sync[2];
  assign load_rise  = load_sync[1] & ~load_sync[2];
  assign presc_edge = presc_sync & ~presc_last;

  // Shift register and the four latches
  logic [`DSM_SR_W-1:0]        shift;
  logic [`DSM_SR_W-1:0]        next_shift;
  logic [1:0][`DSM_WORD_W-1:0] ref_word;
  logic [1:0][`DSM_WORD_W-1:0] div_word;
  logic [1:0][`DSM_WORD_W-1:0] next_ref_word;
  logic [1:0][`DSM_WORD_W-1:0] next_div_word;
  logic [1:0]                  wsel;
  logic [`DSM_WORD_W-1:0]      data_field;
  assign wsel       = {shift[`DSM_WSEL_HI], shift[`DSM_WSEL_LO]};
  assign data_field = shift[`DSM_DATA_MSB:`DSM_DATA_LSB];

  // Latches only move on the strobe, so half-shifted words never reach the loops
  always_comb begin
    next_shift    = shift;
    next_ref_word = ref_word;
    next_div_word = div_word;
    if (clk_rise) begin
      next_shift = {shift[`DSM_SR_W-2:0], ser_data_sync[1]};
    end
    if (load_rise) begin
      case (wsel)
        `DSM_WSEL_AUX_REF:  next_ref_word[`DSM_AUX]  = data_field;
        `DSM_WSEL_MAIN_REF: next_ref_word[`DSM_MAIN] = data_field;
        `DSM_WSEL_AUX_DIV:  next_div_word[`DSM_AUX]  = data_field;
        `DSM_WSEL_MAIN_DIV: next_div_word[`DSM_MAIN] = data_field;
        default:            next_shift = shift;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift    <= `DSM_SR_RST;
      ref_word <= {2{`DSM_WORD_RST}};
      div_word <= {2{`DSM_WORD_RST}};
    end else begin
      shift    <= next_shift;
      ref_word <= next_ref_word;
      div_word <= next_div_word;
    end
  end

  // Status pin function decode; every pattern listed, default kept as a guard
  function automatic dsm_pkg::dsm_status_t decode_status(input logic [3:0] sel);
    case (sel) inside
      4'b0000: decode_status = dsm_pkg::dsm_st_off;
      4'b0100: decode_status = dsm_pkg::dsm_st_lock_aux;
      4'b1000: decode_status = dsm_pkg::dsm_st_lock_main;
      4'b1100: decode_status = dsm_pkg::dsm_st_lock_both;
      4'b?001: decode_status = dsm_pkg::dsm_st_ref_aux;
      4'b?010: decode_status = dsm_pkg::dsm_st_ref_main;
      4'b?101: decode_status = dsm_pkg::dsm_st_fb_aux;
      4'b?110: decode_status = dsm_pkg::dsm_st_fb_main;
      4'b0011: decode_status = dsm_pkg::dsm_st_damp_sw;
      4'b0111: decode_status = dsm_pkg::dsm_st_rst_aux;
      4'b1011: decode_status = dsm_pkg::dsm_st_rst_main;
      4'b1111: decode_status = dsm_pkg::dsm_st_rst_both;
      default: decode_status = dsm_pkg::dsm_st_off;
    endcase
  endfunction : decode_status

  dsm_pkg::dsm_status_t status_mode;
  assign status_mode = decode_status({ref_word[`DSM_MAIN][`DSM_LOCK_BIT], ref_word[`DSM_AUX][`DSM_LOCK_BIT],
                                      ref_word[`DSM_MAIN][`DSM_FUNC_BIT], ref_word[`DSM_AUX][`DSM_FUNC_BIT]});

  // Counter reset requests from the status select modes
  logic [1:0] cnt_reset;
  assign cnt_reset[`DSM_AUX]  = (status_mode == dsm_pkg::dsm_st_rst_aux) ||
                                (status_mode == dsm_pkg::dsm_st_rst_both);
  assign cnt_reset[`DSM_MAIN] = (status_mode == dsm_pkg::dsm_st_rst_main) ||
                                (status_mode == dsm_pkg::dsm_st_rst_both);

  logic [1:0]            hold_cnt;
  logic [1:0]            ref_pulse;
  logic [1:0]            fb_pulse;
  logic [1:0]            pd_up;
  logic [1:0]            pd_dn;
  logic [1:0]            locked;
  dsm_pkg::dsm_pwr_t     pwr_state [2];

  // Per-loop dividers, phase detector, pump drive and power sequencing
  for (genvar i = 0; i < 2; i++) begin : g_loop
    logic [`DSM_A_CNT_W-1:0] swallow_left;
    logic [`DSM_A_CNT_W-1:0] next_swallow_left;
    logic                    next_up;
    logic                    next_dn;
    logic                    div_load;
    dsm_pkg::dsm_pwr_t       next_pwr;

    assign hold_cnt[i] = cnt_reset[i] || (pwr_state[i] == dsm_pkg::dsm_pwr_down);
    assign locked[i]   = ~(pd_up[i] | pd_dn[i]);
    assign div_load    = load_rise && (wsel == {1'b1, 1'(i)});

    // Reference counter counts the reference clock itself
    dsm_prog_div #(.W(`DSM_R_CNT_W)) u_ref_div (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .hold_in    (hold_cnt[i]),
      .tick_in    (1'b1),
      .ratio_in   (ref_word[i][`DSM_R_CNT_MSB:`DSM_R_CNT_LSB]),
      .tc_out     (ref_pulse[i])
    );

    // Main counter counts prescaler output cycles
    dsm_prog_div #(.W(`DSM_B_CNT_W)) u_main_div (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .hold_in    (hold_cnt[i]),
      .tick_in    (presc_edge[i]),
      .ratio_in   (div_word[i][`DSM_B_CNT_MSB:`DSM_B_CNT_LSB]),
      .tc_out     (fb_pulse[i])
    );

    // Swallow count: first A prescaler cycles of each frame use modulus P+1
    always_comb begin
      next_swallow_left = swallow_left;
      next_up           = (pd_up[i] | ref_pulse[i]);
      next_dn           = (pd_dn[i] | fb_pulse[i]);
      if (hold_cnt[i] || fb_pulse[i]) begin
        next_swallow_left = div_word[i][`DSM_A_CNT_MSB:`DSM_A_CNT_LSB];
      end else if (presc_edge[i] && (swallow_left != '0)) begin
        next_swallow_left = swallow_left - `DSM_A_CNT_W'(1);
      end
      if ((next_up && next_dn) || hold_cnt[i]) begin
        next_up = 1'b0; // Both edges seen: detector resets, pump goes idle
        next_dn = 1'b0;
      end
    end

    // Powerdown: floating pump at load time makes it immediate
    always_comb begin
      next_pwr = pwr_state[i];
      case (pwr_state[i])
        dsm_pkg::dsm_pwr_up, dsm_pkg::dsm_pwr_wait, dsm_pkg::dsm_pwr_down: begin
          if (div_load) begin
            if (!data_field[`DSM_PWD_BIT]) begin
              next_pwr = dsm_pkg::dsm_pwr_up;
            end else if (ref_word[i][`DSM_FLT_BIT]) begin
              next_pwr = dsm_pkg::dsm_pwr_down;
            end else begin
              next_pwr = dsm_pkg::dsm_pwr_wait;
            end
          end else if ((pwr_state[i] == dsm_pkg::dsm_pwr_wait) && locked[i]) begin
            next_pwr = dsm_pkg::dsm_pwr_down;
          end
        end
        default: next_pwr = dsm_pkg::dsm_pwr_up;
      endcase
    end

    // Pump polarity swaps source and sink; float covers the float bit, counter reset and powerdown
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        swallow_left            <= '0;
        pd_up[i]                <= 1'b0;
        pd_dn[i]                <= 1'b0;
        pwr_state[i]            <= dsm_pkg::dsm_pwr_up;
        mod_ctl_out[i]          <= 1'b0;
        prescaler_sel_out[i]    <= 1'b0;
        pump_src_out[i]         <= 1'b0;
        pump_snk_out[i]         <= 1'b0;
        pump_float_out[i]       <= 1'b0;
        pump_current_sel_out[i] <= 1'b0;
        powerdown_out[i]        <= 1'b0;
      end else begin
        swallow_left            <= next_swallow_left;
        pd_up[i]                <= next_up;
        pd_dn[i]                <= next_dn;
        pwr_state[i]            <= next_pwr;
        mod_ctl_out[i]          <= (next_swallow_left != '0);
        prescaler_sel_out[i]    <= div_word[i][`DSM_PSC_BIT];
        pump_src_out[i]         <= ref_word[i][`DSM_POL_BIT] ? next_up : next_dn;
        pump_snk_out[i]         <= ref_word[i][`DSM_POL_BIT] ? next_dn : next_up;
        pump_float_out[i]       <= ref_word[i][`DSM_FLT_BIT] || cnt_reset[i] ||
                                   (next_pwr == dsm_pkg::dsm_pwr_down);
        pump_current_sel_out[i] <= ref_word[i][`DSM_CUR_BIT];
        powerdown_out[i]        <= (next_pwr == dsm_pkg::dsm_pwr_down);
      end
    end
  end : g_loop

  // Status pin mux; only the damping switch mode releases the pin (open drain)
  logic next_pin;
  logic next_pin_oe;
  always_comb begin
    next_pin    = 1'b0;
    next_pin_oe = 1'b1;
    case (status_mode)
      dsm_pkg::dsm_st_lock_aux:  next_pin = locked[`DSM_AUX];
      dsm_pkg::dsm_st_lock_main: next_pin = locked[`DSM_MAIN];
      dsm_pkg::dsm_st_lock_both: next_pin = locked[`DSM_AUX] & locked[`DSM_MAIN];
      dsm_pkg::dsm_st_ref_aux:   next_pin = ref_pulse[`DSM_AUX];
      dsm_pkg::dsm_st_ref_main:  next_pin = ref_pulse[`DSM_MAIN];
      dsm_pkg::dsm_st_fb_aux:    next_pin = fb_pulse[`DSM_AUX];
      dsm_pkg::dsm_st_fb_main:   next_pin = fb_pulse[`DSM_MAIN];
      dsm_pkg::dsm_st_damp_sw:   next_pin_oe = ref_word[`DSM_MAIN][`DSM_CUR_BIT];
      default:                  next_pin = 1'b0;
    endcase
  end

  // Oscillator stops only when both loops are down
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_mux_pin_out    <= 1'b0;
      status_mux_pin_oe_out <= 1'b1;
      osc_enable_out        <= 1'b1;
    end else begin
      status_mux_pin_out    <= next_pin;
      status_mux_pin_oe_out <= next_pin_oe;
      osc_enable_out        <= (pwr_state[0] != dsm_pkg::dsm_pwr_down) || (pwr_state[1] != dsm_pkg::dsm_pwr_down);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_pin_disabled: assert property (status_mode == dsm_pkg::dsm_st_off |=> status_mux_pin_oe_out && !status_mux_pin_out)
    else $error("disabled status pin not driven low");
  a_lock_main: assert property (status_mode == dsm_pkg::dsm_st_lock_main |=> status_mux_pin_out == $past(locked[1]))
    else $error("main lock not shown on status pin");
  a_lock_both: assert property (status_mode == dsm_pkg::dsm_st_lock_both |=>
                               status_mux_pin_out == ($past(locked[0]) && $past(locked[1])))
    else $error("combined lock wrong on status pin");
  a_ref_route: assert property (status_mode == dsm_pkg::dsm_st_ref_aux |=> status_mux_pin_out == $past(ref_pulse[0]))
    else $error("aux reference output not routed");
  a_fb_route: assert property (status_mode == dsm_pkg::dsm_st_fb_main |=> status_mux_pin_out == $past(fb_pulse[1]))
    else $error("main feedback output not routed");
  a_damp_drain: assert property (status_mode == dsm_pkg::dsm_st_damp_sw |=>
                                !status_mux_pin_out && status_mux_pin_oe_out == $past(ref_word[1][`DSM_CUR_BIT]))
    else $error("damping switch wrong");
  a_reset_float: assert property (cnt_reset[0] && cnt_reset[1] |=> pump_float_out == 2'h3 && ref_pulse == 2'h0)
    else $error("counter reset did not float pumps");
  a_load_route: assert property (load_rise && wsel == `DSM_WSEL_MAIN_REF |=> ref_word[1] == $past(data_field))
    else $error("main reference word not latched");
  a_latch_hold: assert property (!load_rise |=> $stable(ref_word) && $stable(div_word))
    else $error("latch changed without load strobe");
  a_async_pwd: assert property (load_rise && wsel == `DSM_WSEL_MAIN_DIV && data_field[`DSM_PWD_BIT] &&
                               ref_word[1][`DSM_FLT_BIT] |=> powerdown_out[1])
    else $error("asynchronous powerdown not immediate");
  a_sync_pwd_wait: assert property (pwr_state[0] == dsm_pkg::dsm_pwr_wait && !locked[0] && !load_rise
                                    |=> !powerdown_out[0])
    else $error("synchronous powerdown before pump idle");
  a_prescaler: assert property (##1 prescaler_sel_out[1] == $past(div_word[1][`DSM_PSC_BIT]))
    else $error("prescaler select does not follow divider word");

  c_damp_sw: cover property (status_mode == dsm_pkg::dsm_st_damp_sw && status_mux_pin_oe_out);
  c_sync_pwd: cover property (pwr_state[0] == dsm_pkg::dsm_pwr_wait ##[1:200] pwr_state[0] == dsm_pkg::dsm_pwr_down);
  c_both_lock: cover property (status_mode == dsm_pkg::dsm_st_lock_both && status_mux_pin_out);
  c_main_div_load: cover property (load_rise && wsel == `DSM_WSEL_MAIN_DIV);

endmodule : dsm_mode_ctrl

// [dsm_host_model.sv]
// Host model that drives the three-wire programming port of the mode control
`timescale 1ns/1ps
module dsm_host_model (
  input  wire logic ref_clk_in,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      load_strobe_out
);
  // Each level held 3 reference clocks, above the 2-clock synchroniser minimum
  localparam int HOLD = 3;

  // Port idles low before the first frame
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end

  // One 22-bit frame, most significant bit first, then the strobe
  task automatic send(input logic [21:0] w);
    for (int i = 21; i >= 0; i--) begin
      ser_data_out = w[i];
      repeat (HOLD) @(negedge ref_clk_in);
      ser_clk_out = 1'b1;
      repeat (HOLD) @(negedge ref_clk_in);
      ser_clk_out = 1'b0;
    end
    // Hold time is over: show the inverse so a stale sample cannot pass
    ser_data_out = ~w[0];
    repeat (HOLD) @(negedge ref_clk_in);
    load_strobe_out = 1'b1;
    repeat (HOLD) @(negedge ref_clk_in);
    load_strobe_out = 1'b0;
    repeat (HOLD) @(negedge ref_clk_in);
  endtask : send
endmodule : dsm_host_model

// [dsm_mode_ctrl_tb.sv]
// Self-checking testbench for the dual synthesizer mode control
`timescale 1ns/1ps
module dsm_mode_ctrl_tb;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ser_clk, ser_data, load_strobe;
  logic [1:0]  presc_pulse = 2'h0;
  logic [1:0]  mod_ctl, presc_sel, pump_src, pump_snk, pump_float, pump_cur, pwd;
  logic        osc_en, pin, pin_oe;
  logic        presc_run = 1'b0;
  logic [31:0] rng = 32'h783a31d7;
  logic [19:0] ref_w [2] = '{20'h00000, 20'h00000};
  logic [19:0] div_w [2] = '{20'h00000, 20'h00000};
  int          error_cnt = 0;
  int          cmp_count = 0;

  // 20 MHz reference clock
  always #25 ref_clk_in = ~ref_clk_in;

  // Both prescaler outputs, one rising edge every 2 clocks when running
  always @(negedge ref_clk_in) if (presc_run) presc_pulse <= presc_pulse ^ 2'h3;

  dsm_host_model i_dsm_host_model (
    .ref_clk_in      (ref_clk_in),
    .ser_clk_out     (ser_clk),
    .ser_data_out    (ser_data),
    .load_strobe_out (load_strobe)
  );

  dsm_mode_ctrl i_dsm_mode_ctrl (
    .ref_clk_in            (ref_clk_in),
    .reset_n_in            (reset_n_in),
    .ser_clk_in            (ser_clk),
    .ser_data_in           (ser_data),
    .load_strobe_in        (load_strobe),
    .presc_pulse_in        (presc_pulse),
    .mod_ctl_out           (mod_ctl),
    .prescaler_sel_out     (presc_sel),
    .pump_src_out          (pump_src),
    .pump_snk_out          (pump_snk),
    .pump_float_out        (pump_float),
    .pump_current_sel_out  (pump_cur),
    .powerdown_out         (pwd),
    .osc_enable_out        (osc_en),
    .status_mux_pin_out    (pin),
    .status_mux_pin_oe_out (pin_oe)
  );

  // Fixed-seed xorshift source for legal field values
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Compare every level output with the latch model
  task automatic check_all();
    logic [1:0] e_flt;
    logic       rst_mode;
    rst_mode = ref_w[0][19] & ref_w[1][19];
    // A powered-down loop floats its pump as well
    for (int l = 0; l < 2; l++) e_flt[l] = ref_w[l][17] | (rst_mode & ref_w[l][18]) | div_w[l][19];
    chk("prescaler_sel", {14'h0, div_w[1][18], div_w[0][18]}, {14'h0, presc_sel});
    chk("pump_current", {14'h0, ref_w[1][16], ref_w[0][16]}, {14'h0, pump_cur});
    chk("pump_float", {14'h0, e_flt}, {14'h0, pump_float});
    chk("powerdown", {14'h0, div_w[1][19], div_w[0][19]}, {14'h0, pwd});
    chk("osc_enable", {15'h0, ~(div_w[0][19] & div_w[1][19])}, {15'h0, osc_en});
    if (rst_mode && !ref_w[0][18] && !ref_w[1][18]) begin
      chk("damp_oe", {15'h0, ref_w[1][16]}, {15'h0, pin_oe});
      chk("damp_pin", 16'h0, {15'h0, pin});
    end
    if ({ref_w[0][19:18], ref_w[1][19:18]} == 4'h0) begin
      chk("off_oe", 16'h1, {15'h0, pin_oe});
      chk("off_pin", 16'h0, {15'h0, pin});
    end
  endtask : check_all

  // Send a word, update the model, let the outputs settle, compare
  task automatic load(input logic [1:0] sel, input logic [19:0] w);
    i_dsm_host_model.send({w, sel});
    if (sel[1]) div_w[sel[0]] = w;
    else ref_w[sel[0]] = w;
    repeat (8) @(negedge ref_clk_in);
    check_all();
  endtask : load

  // Pin pulses, swallow frames and main pump sides over 60 clocks, one of phase slack
  task automatic count_pulses(input string nm, input logic [15:0] e, input logic [15:0] e_mod);
    logic [15:0] n;
    logic [15:0] m;
    logic [15:0] s;
    logic [15:0] k;
    logic        pm;
    n = 16'h0;
    m = 16'h0;
    s = 16'h0;
    k = 16'h0;
    pm = mod_ctl[1];
    repeat (60) begin
      @(negedge ref_clk_in);
      n = n + {15'h0, pin};
      m = m + {15'h0, mod_ctl[1] & ~pm};
      s = s + {15'h0, pump_src[1]};
      k = k + {15'h0, pump_snk[1]};
      pm = mod_ctl[1];
    end
    chk(nm, e, (n + 16'h1 >= e && n <= e + 16'h1) ? e : n);
    chk("swallow_frames", e_mod, (m + 16'h1 >= e_mod && m <= e_mod + 16'h1) ? e_mod : m);
    // Reference runs ahead of feedback, so only the up request may reach the pump
    chk("pump_wrong_side", 16'h0, ref_w[1][15] ? k : s);
    chk("pump_right_side", 16'h1, {15'h0, (ref_w[1][15] ? s : k) != 16'h0});
  endtask : count_pulses

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Cut a hang short: the scenarios need about 5200 clocks
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [10:0] b;
    logic [6:0]  a;
    repeat (2) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    check_all();
    // Random legal words to both loops, powerdown kept low
    for (int k = 0; k < 6; k++) begin
      r = xs();
      b = 11'(3 + r[15:0] % 2045);
      a = 7'(r[23:16] % 65);
      if (a > 7'(b)) a = 7'(b);
      load({1'b0, r[24]}, {2'h0, r[27:25], 15'(3 + r[14:0] % 32765)});
      load({1'b1, r[24]}, {1'b0, r[31], b, a});
    end
    // Immediate powerdown with float set, oscillator off only with both down
    load(2'h0, 20'h20003);
    load(2'h2, 20'h80180);
    load(2'h1, 20'h20003);
    load(2'h3, 20'h80180);
    load(2'h3, 20'h00180);
    load(2'h2, 20'h00180);
    // Open-drain damping switch follows main pump current bit
    load(2'h0, 20'h80003);
    load(2'h1, 20'h90003);
    load(2'h1, 20'h80003);
    // Counter reset modes float the chosen pumps
    for (int m = 1; m < 4; m++) begin
      load(2'h0, {1'b1, m[0], 3'h0, 15'h0003});
      load(2'h1, {1'b1, m[1], 3'h0, 15'h0003});
    end
    // Aux reference divider by 3 on the pin
    load(2'h1, 20'h00003);
    load(2'h0, 20'h80003);
    count_pulses("ref_pulses", 16'h0014, 16'h0000);
    // Main feedback divider by 3 prescaler edges on the pin, one swallow cycle, positive polarity
    load(2'h0, 20'h40005);
    load(2'h1, 20'h88003);
    load(2'h3, 20'h00181);
    presc_run = 1'b1;
    repeat (12) @(negedge ref_clk_in);
    count_pulses("fb_pulses", 16'h000a, 16'h000a);
    // Aux powerdown with float clear waits for an idle pump, then comes up again
    load(2'h2, 20'h80180);
    load(2'h2, 20'h00180);
    print_verdict();
  end
endmodule : dsm_mode_ctrl_tb
